// [sim/bawc_arbiter_assertions.sv]
`timescale 1ns/100ps
// ---------------------------------
// grant and timing checker
// ---------------------------------
module bawc_arbiter_assertions (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire clk_en,
  // register bus and masters
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire core_cycle_end,
  input wire core_split,
  input wire core_rmw,
  input wire core_sleep,
  input wire event_transfer_unit_release,
  input wire external_bus_dma_unit_req,
  input wire ext_release_req,
  input wire dma_unit_go,
  input wire [4:0] grant,
  // access timing
  input wire [1:0] column_states,
  input wire precharge_extend
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  reg [3:0] pe_run;
  // length of the current extension run, saturating so it cannot wrap
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pe_run <= 4'h0;
    end else begin
      pe_run <= precharge_extend ? pe_run + {3'h0, pe_run != 4'hf} : 4'h0;
    end
  end
  chk_grant_onehot: assert property ($onehot(grant))
    else $error("grant not one-hot");
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bad bus answer");
  chk_go_granted: assert property (dma_unit_go |-> grant[2] ##1 !dma_unit_go)
    else $error("go without grant");
  chk_core_split: assert property (grant[0] && core_split && !core_sleep |=> grant[0])
    else $error("split access broken");
  chk_core_rmw: assert property (grant[0] && core_rmw && !core_sleep |=> grant[0])
    else $error("rmw sequence broken");
  chk_core_boundary: assert property (grant[0] && !core_cycle_end && !core_sleep
    |=> grant[0]) else $error("core yielded mid cycle");
  chk_sleep_handover: assert property (grant[0] && core_sleep &&
    external_bus_dma_unit_req && !ext_release_req |=> grant[3]) else $error("sleep slow");
  chk_etu_hold: assert property (grant[1] && !event_transfer_unit_release
    |=> grant[1]) else $error("event unit lost bus");
  chk_exdma_hold: assert property (grant[3] && external_bus_dma_unit_req |=> grant[3])
    else $error("ext dma lost bus");
  chk_col_states: assert property (column_states == 2'h2 || column_states == 2'h3)
    else $error("bad column length");
  chk_pre_len: assert property (pe_run <= 4'h7)
    else $error("precharge too long");
endmodule

bind bawc_arbiter bawc_arbiter_assertions u_chk (.clk(clk), .rst(rst), .clk_en(clk_en),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .core_cycle_end(core_cycle_end), .core_split(core_split), .core_rmw(core_rmw),
  .core_sleep(core_sleep), .event_transfer_unit_release(event_transfer_unit_release),
  .external_bus_dma_unit_req(external_bus_dma_unit_req), .ext_release_req(ext_release_req),
  .dma_unit_go(dma_unit_go), .grant(grant), .column_states(column_states),
  .precharge_extend(precharge_extend));

// [sim/bawc_arbiter_tb.sv]
`timescale 1ns/100ps
module bawc_arbiter_tb;
  // ---------------------------------
  // signals
  // ---------------------------------
  reg clk = 1'b0;
  reg rst, avs_read, avs_write, core_split, core_rmw, core_sleep, etu_act, etu_rel, pin_n;
  reg exdma_req, rel_req, sr_exit, slow, prev0, clk_en;
  reg [3:0] avs_address;
  reg [31:0] avs_writedata, rd;
  reg [2:0] access_area;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, cyc_end, done, go, head, tail, pre_ext;
  wire [4:0] grant;
  wire [2:0] waits;
  wire [1:0] col;
  int n_fail, samples_checked, cyc, n_go, n_back, i;
  bawc_arbiter DUT (.clk(clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_cycle_end(cyc_end),
    .core_split(core_split), .core_rmw(core_rmw), .core_sleep(core_sleep),
    .event_transfer_unit_act(etu_act), .event_transfer_unit_release(etu_rel),
    .transfer_request_pin_n(pin_n), .dma_unit_done(done), .dma_unit_go(go),
    .external_bus_dma_unit_req(exdma_req), .ext_release_req(rel_req), .grant(grant),
    .access_area(access_area), .self_refresh_exit(sr_exit), .program_waits(waits),
    .head_extend(head), .tail_extend(tail), .column_states(col), .precharge_extend(pre_ext));
  bawc_partner u_far (.clk(clk), .rst(rst), .slow(slow), .dma_unit_go(go),
    .dma_unit_done(done), .core_cycle_end(cyc_end));
  always #50 clk = ~clk;
  // unit and core-return counters; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    n_go = n_go + (go === 1'b1);
    n_back = n_back + (grant[0] === 1'b1 && prev0 !== 1'b1);
    prev0 = grant[0];
    cyc = cyc + 1;
    if (cyc > 20000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  // ---------------------------------
  // helpers
  // ---------------------------------
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  // one avalon access; held until waitrequest is seen low
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wait_grant(input logic [4:0] g);
    for (i = 0; i < 80 && grant !== g; i++) @(posedge clk);
    cmp({27'h0, grant}, {27'h0, g});
  endtask
  // ---------------------------------
  // scenarios
  // ---------------------------------
  task t_regs;
    av(0, 4'h0, 0); cmp(rd, 32'h77);
    av(1, 4'h0, 32'hff); av(0, 4'h0, 0); cmp(rd, 32'h77);
    av(1, 4'hf, 32'h5a); av(0, 4'hf, 0); cmp(rd, 32'h0);
    av(1, 4'h0, 32'h25); access_area <= 3'h5; step(3); cmp({29'h0, waits}, 32'h2);
    access_area <= 3'h4; step(3); cmp({29'h0, waits}, 32'h5);
    clk_en <= 1'b0; access_area <= 3'h5; step(3); cmp({29'h0, waits}, 32'h5);
    clk_en <= 1'b1; access_area <= 3'h4;
    av(1, 4'h0, 32'h0); step(2); cmp({29'h0, waits}, 32'h0);
    cmp({30'h0, col}, 32'h2); av(1, 4'h3, 32'h1); step(2); cmp({30'h0, col}, 32'h3);
    av(1, 4'h2, 32'h2010); step(3); cmp({30'h0, head, tail}, 32'h1);
    access_area <= 3'h5; step(3); cmp({30'h0, head, tail}, 32'h2);
    av(1, 4'h4, 32'h3); sr_exit <= 1'b1; step(1); sr_exit <= 1'b0; n_back = 0;
    for (i = 0; i < 20; i++) begin step(1); n_back = n_back + (pre_ext === 1'b1); end
    cmp(n_back, 3);
    $display("register test done");
  endtask
  task t_arb;
    for (int k = 0; k < 2; k++) begin
      core_split <= (k == 0);
      core_rmw <= (k == 1);
      etu_act <= 1'b1; step(1); etu_act <= 1'b0; step(8);
      cmp({27'h0, grant}, 32'h1);
      core_split <= 1'b0; core_rmw <= 1'b0; wait_grant(5'h02);
      step(4); cmp({27'h0, grant}, 32'h2);
      etu_rel <= 1'b1; step(1); etu_rel <= 1'b0; wait_grant(5'h01);
    end
    core_sleep <= 1'b1; exdma_req <= 1'b1; step(2); cmp({27'h0, grant}, 32'h8);
    rel_req <= 1'b1; step(4); cmp({27'h0, grant}, 32'h8);
    exdma_req <= 1'b0; wait_grant(5'h10);
    rel_req <= 1'b0; core_sleep <= 1'b0; wait_grant(5'h01);
    $display("arbitration test done");
  endtask
  // request pin only ever driven as an input, one edge per finished unit in edge mode, then held low in level mode
  task t_pin;
    av(1, 4'h6, 32'h8); av(1, 4'h5, 32'h5); n_go = 0;
    for (int k = 1; k < 3; k++) begin
      pin_n <= 1'b0; step(1); pin_n <= 1'b1; step(30);
      cmp(n_go, k); wait_grant(5'h01);
    end
    av(1, 4'h5, 32'h1); slow <= 1'b1; n_back = 0; pin_n <= 1'b0;
    for (i = 0; i < 300 && n_go < 5; i++) step(1);
    pin_n <= 1'b1; step(12); n_go = 0; step(30);
    cmp(n_go, 0); cmp(n_back >= 2, 1);
    av(1, 4'h5, 32'h0); slow <= 1'b0;
    $display("request pin test done");
  endtask
  task t_auto;
    for (int m = 0; m < 3; m++) begin
      av(1, 4'h7, 32'h3); av(1, 4'h6, 32'h3); n_go = 0; n_back = 0;
      av(1, 4'h5, {27'h0, m[1:0], 3'h3});
      for (i = 0; i < 300 && (n_go < 3 || grant !== 5'h01); i++) step(1);
      step(10); cmp(n_go, 3);
      cmp(n_back, (m == 0) ? 3 : 1);
      av(1, 4'h5, 32'h0);
    end
    $display("auto request test done");
  endtask
  // burst cut short by the external-bus dma at the first gap, then resumed
  task t_preempt;
    av(1, 4'h6, 32'h4); n_go = 0; av(1, 4'h5, 32'h13);
    for (i = 0; i < 80 && n_go < 1; i++) step(1);
    exdma_req <= 1'b1; wait_grant(5'h08); cmp(n_go, 1);
    exdma_req <= 1'b0;
    for (i = 0; i < 300 && (n_go < 4 || grant !== 5'h01); i++) step(1);
    cmp(n_go, 4); av(1, 4'h5, 32'h0);
    $display("pre-emption test done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // reset for 16 cycles, then the scenarios in turn
  initial begin
    {rst, avs_read, avs_write, core_split, core_rmw, core_sleep, etu_act, etu_rel} = 8'h80;
    {pin_n, exdma_req, rel_req, sr_exit, slow, clk_en} = 6'h21;
    {avs_address, avs_writedata, access_area} = 39'h0;
    {n_fail, samples_checked, cyc, n_go, n_back} = 0;
    step(16);
    rst <= 1'b0;
    step(1);
    t_regs;
    t_arb;
    t_pin;
    t_auto;
    t_preempt;
    end_sim;
  end
endmodule

// [sim/bawc_partner.sv]
`timescale 1ns/100ps
// ---------------------------------
// far side: data mover and core
// ---------------------------------
module bawc_partner (
  // clock and reset
  input wire clk,
  input wire rst,
  // answer speed select
  input wire slow,
  // dma mover
  input wire dma_unit_go,
  output reg dma_unit_done,
  // core bus cycles
  output reg core_cycle_end
);
  reg [2:0] busy;
  reg [1:0] phase;
  // one done per go, after 2 or 5 cycles; never a spare done
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 3'h0;
      dma_unit_done <= 1'b0;
    end else begin
      dma_unit_done <= (busy == 3'h1);
      if (dma_unit_go) begin
        busy <= slow ? 3'h4 : 3'h1;
      end else if (busy != 3'h0) begin
        busy <= busy - 3'h1;
      end
    end
  end
  // core runs three-state bus cycles back to back
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      core_cycle_end <= 1'b0;
    end else begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      core_cycle_end <= (phase == 2'h1);
    end
  end
endmodule

// [verilog/bawc_arbiter.v]
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
// Behaviour
// - core is lowest priority; any other requester takes the bus.
// - core yields only between bus cycles, never inside a split access.
// - core keeps the bus across a whole read-modify-write sequence.
// - sleeping core hands the bus over at once.
// - event transfer unit requests the bus on its activation request.
// - event transfer unit releases only at its documented release points.
// - dma unit requests the bus whenever it has an activation request.
// - external-request and cycle-steal dma release after each single transfer.
// - block mode releases per block; burst mode only at transfer end.
// - external-bus dma or bus-release request pre-empts block or burst dma.
// - edge sensing moves one unit per falling edge of the request pin; a second fall before the unit starts merges into the pending one.
// - level sensing idles while pin high, transfers unit by unit while low.
// - pin going high during a level sequence stops further transfers.
// - auto-request starts from register setting and runs to the end.
// - cycle-steal yields after every unit; burst holds bus to the end.
// - area 5 wait field gives 0..7 waits, resets 111, bit 7 reads 0.
// - area 4 wait field bits 2..0 gives 0..7 waits, resets 111, bit 3 reads 0.
// - per-area head and tail extension states from upper and lower byte.
// - column-cycle extend bit lengthens column address cycle from 2 to 3.
// - after self-refresh clear add 1..7 extra precharge states.
`include "bawc_defs.vh"

module bawc_arbiter (
  // clock, reset, enable
  input wire clk,
  input wire rst,
  input wire clk_en,
  // avalon-mm register slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // processor core
  input wire core_cycle_end,
  input wire core_split,
  input wire core_rmw,
  input wire core_sleep,
  // event transfer unit
  input wire event_transfer_unit_act,
  input wire event_transfer_unit_release,
  // dma unit
  input wire transfer_request_pin_n,
  input wire dma_unit_done,
  output reg dma_unit_go,
  // external-bus dma and bus release request
  input wire external_bus_dma_unit_req,
  input wire ext_release_req,
  // grant, one-hot
  output reg [`BAWC_GW-1:0] grant,
  // access timing for the current cycle
  input wire [2:0] access_area,
  input wire self_refresh_exit,
  output reg [2:0] program_waits,
  output reg head_extend,
  output reg tail_extend,
  output reg [1:0] column_states,
  output reg precharge_extend
);

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  // software-visible settings; the dma counters live in the sequencer
  reg [7:0] area45_wait_ctrl;
  reg [7:0] access_state_ctrl;
  reg [15:0] select_extend_ctrl;
  reg column_cycle_extend;
  reg [2:0] post_self_refresh_precharge;
  reg [4:0] dma_ctrl;
  reg [15:0] dma_count;
  reg [15:0] dma_block;

  // a write lands at the edge where waitrequest is seen low
  wire wr_go = avs_write & ~avs_waitrequest;
  wire dma_en = dma_ctrl[`BAWC_DC_EN];
  wire dma_auto = dma_ctrl[`BAWC_DC_AUTO];
  wire dma_edge = dma_ctrl[`BAWC_DC_EDGE];
  wire [1:0] dma_mode = dma_ctrl[`BAWC_DC_MODE_HI:`BAWC_DC_MODE_LO];

  // -------------------------------------------------------------
  // dma request detection
  // -------------------------------------------------------------
  // pin_prev resets high, the pin's idle level, so reset makes no false edge
  reg pin_prev;
  reg edge_pend;
  wire pin_fall = pin_prev & ~transfer_request_pin_n;

  // dma state machine
  localparam D_IDLE = 2'h0;
  localparam D_REQ = 2'h1;
  localparam D_XFER = 2'h2;
  localparam D_GAP = 2'h3;
  reg [1:0] dma_state;
  reg [15:0] blk_left;

  wire dma_has_grant = grant[`BAWC_G_DMA];
  // blk_last is judged before the decrement, in the transfer state
  wire blk_last = (blk_left == 16'h0001);
  // the gap state sees the counts after the decrement: nothing left means
  // the transfer is over, a reloaded block counter means the block is over
  // (a block size rewritten in mid-transfer can fool this)
  wire dma_over = (dma_count == 16'h0000);
  wire blk_over = (blk_left == dma_block);

  // activation: auto runs while count remains, external by pin sense
  // the count guard ends an auto-request run at the end of the transfer
  reg dma_act;
  always @* begin
    dma_act = 1'b0;
    if (dma_en && dma_count != 16'h0000) begin
      if (dma_auto)
        dma_act = 1'b1;
      else if (dma_edge)
        dma_act = edge_pend;
      else
        dma_act = ~transfer_request_pin_n;
    end
  end

  // release decision after a unit completes
  // external-request and cycle-steal transfers never keep the bus
  reg dma_keep;
  always @* begin
    dma_keep = 1'b0;
    if (dma_auto && dma_mode == `BAWC_MODE_BURST)
      dma_keep = ~dma_over;
    else if (dma_auto && dma_mode == `BAWC_MODE_BLOCK)
      dma_keep = ~dma_over & ~blk_over;
  end

  // a higher master may cut into block or burst only between units
  // it never breaks into a unit already under way
  wire hi_req = external_bus_dma_unit_req | ext_release_req;
  wire dma_rel_pt = (dma_state == D_GAP) &
    (~dma_keep | hi_req | ~dma_act);

  // -------------------------------------------------------------
  // dma sequencer
  // -------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_state <= D_IDLE;
      dma_unit_go <= 1'b0;
      pin_prev <= 1'b1;
      edge_pend <= 1'b0;
      dma_count <= 16'h0000;
      blk_left <= 16'h0000;
    end else if (clk_en) begin
      pin_prev <= transfer_request_pin_n;
      dma_unit_go <= 1'b0;
      // edge latch; set wins over consume
      // a second fall before the unit starts merges into the pending one
      if (pin_fall && dma_edge)
        edge_pend <= 1'b1;
      else if (dma_unit_go && dma_edge)
        edge_pend <= 1'b0;
      if (wr_go && avs_address == `BAWC_IDX_DMACNT) begin
        dma_count <= avs_writedata[15:0];
        blk_left <= dma_block;
      end
      case (dma_state)
        D_IDLE: begin
          if (dma_act)
            dma_state <= D_REQ;
        end
        D_REQ: begin
          if (!dma_act) begin
            dma_state <= D_IDLE;
          end else if (dma_has_grant) begin
            dma_unit_go <= 1'b1;
            dma_state <= D_XFER;
          end
        end
        D_XFER: begin
          // counters step once per finished unit
          if (dma_unit_done) begin
            dma_count <= dma_count - 16'h0001;
            blk_left <= blk_last ? dma_block : blk_left - 16'h0001;
            dma_state <= D_GAP;
          end
        end
        D_GAP: begin
          // single-transfer release
          // the next unit follows at once only while block or burst keeps the bus
          if (dma_rel_pt)
            dma_state <= D_IDLE;
          else if (dma_act && dma_has_grant) begin
            dma_unit_go <= 1'b1;
            dma_state <= D_XFER;
          end
        end
        default: dma_state <= D_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------
  // arbitration
  // -------------------------------------------------------------
  // requests by priority; core asks implicitly when nobody else does
  wire etu_req;
  reg etu_pend;
  assign etu_req = event_transfer_unit_act | etu_pend;
  // the dma unit asks from its request state to the end of its gap
  wire dma_req = (dma_state != D_IDLE);

  // core release points
  // split and read-modify-write sequences hold the bus; sleep frees it at once
  wire core_rel = core_sleep |
    (core_cycle_end & ~core_split & ~core_rmw);

  // release point of the current owner
  // a code outside the one-hot set releases at once so it cannot lock the bus
  reg owner_rel;
  always @* begin
    case (grant)
      `BAWC_GRANT_CORE: owner_rel = core_rel;
      `BAWC_GRANT_ETU: owner_rel = event_transfer_unit_release;
      `BAWC_GRANT_DMA: owner_rel = dma_rel_pt | (dma_state == D_IDLE);
      `BAWC_GRANT_EXDMA: owner_rel = ~external_bus_dma_unit_req;
      `BAWC_GRANT_EXTREL: owner_rel = ~ext_release_req;
      default: owner_rel = 1'b1;
    endcase
  end

  // winner among requesters other than the leaving owner
  // skipping the leaving owner keeps it from winning the bus straight back
  reg [`BAWC_GW-1:0] next_grant;
  always @* begin
    next_grant = `BAWC_GRANT_CORE;
    if (ext_release_req && !grant[`BAWC_G_EXTREL])
      next_grant = `BAWC_GRANT_EXTREL;
    else if (external_bus_dma_unit_req && !grant[`BAWC_G_EXDMA])
      next_grant = `BAWC_GRANT_EXDMA;
    else if (dma_req && !dma_rel_pt && !grant[`BAWC_G_DMA])
      next_grant = `BAWC_GRANT_DMA;
    else if (etu_req && !grant[`BAWC_G_ETU])
      next_grant = `BAWC_GRANT_ETU;
  end

  // any waiting master at all
  wire want = ext_release_req | external_bus_dma_unit_req |
    (dma_req & ~grant[`BAWC_G_DMA]) | (etu_req & ~grant[`BAWC_G_ETU]);

  // one owner, changes only at a release point
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      grant <= `BAWC_GRANT_CORE;
      etu_pend <= 1'b0;
    end else if (clk_en) begin
      // pending activation held until the unit owns the bus
      if (event_transfer_unit_act)
        etu_pend <= 1'b1;
      else if (grant[`BAWC_G_ETU])
        etu_pend <= 1'b0;
      if (owner_rel && (want || !grant[`BAWC_G_CORE]))
        grant <= next_grant;
    end
  end

  // -------------------------------------------------------------
  // access timing outputs
  // -------------------------------------------------------------
  // every timing output is registered one clock behind access_area, the exit pulse or, for column_states, column_cycle_extend
  reg [2:0] pre_cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      program_waits <= 3'h0;
      head_extend <= 1'b0;
      tail_extend <= 1'b0;
      column_states <= `BAWC_COL_NORM;
      precharge_extend <= 1'b0;
      pre_cnt <= 3'h0;
    end else if (clk_en) begin
      // waits only on slow areas 4 and 5
      if (access_area == `BAWC_AREA5 && access_state_ctrl[`BAWC_AREA5])
        program_waits <= area45_wait_ctrl[`BAWC_W5_HI:`BAWC_W5_LO];
      else if (access_area == `BAWC_AREA4 && access_state_ctrl[`BAWC_AREA4])
        program_waits <= area45_wait_ctrl[`BAWC_W4_HI:`BAWC_W4_LO];
      else
        program_waits <= 3'h0;
      head_extend <= select_extend_ctrl[{1'b1, access_area}];
      tail_extend <= select_extend_ctrl[{1'b0, access_area}];
      column_states <= column_cycle_extend ? `BAWC_COL_LONG : `BAWC_COL_NORM;
      // extra precharge count
      // the exit pulse opens the first extra state, so the run is the field long
      if (self_refresh_exit)
        pre_cnt <= post_self_refresh_precharge;
      else if (pre_cnt != 3'h0)
        pre_cnt <= pre_cnt - 3'h1;
      precharge_extend <= self_refresh_exit ?
        (post_self_refresh_precharge != 3'h0) : (pre_cnt > 3'h1);
    end
  end

  // -------------------------------------------------------------
  // register bus
  // -------------------------------------------------------------
  // one wait cycle per access keeps the read mux off the bus path
  reg [31:0] rd_mux;
  always @* begin
    case (avs_address)
      `BAWC_IDX_WAIT45: rd_mux = {24'h000000, area45_wait_ctrl};
      `BAWC_IDX_ASTATE: rd_mux = {24'h000000, access_state_ctrl};
      `BAWC_IDX_CSEXT: rd_mux = {16'h0000, select_extend_ctrl};
      `BAWC_IDX_DRAM: rd_mux = {31'h00000000, column_cycle_extend};
      `BAWC_IDX_REFR: rd_mux = {29'h00000000, post_self_refresh_precharge};
      `BAWC_IDX_DMACTL: rd_mux = {27'h0000000, dma_ctrl};
      `BAWC_IDX_DMACNT: rd_mux = {16'h0000, dma_count};
      `BAWC_IDX_DMABLK: rd_mux = {16'h0000, dma_block};
      // status is read-only: edge flag, sequencer state, grant
      `BAWC_IDX_STATUS: rd_mux = {24'h000000, edge_pend, dma_state, grant};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      area45_wait_ctrl <= `BAWC_RST_WAIT45;
      access_state_ctrl <= `BAWC_RST_ASTATE;
      select_extend_ctrl <= `BAWC_RST_CSEXT;
      column_cycle_extend <= 1'b0;
      post_self_refresh_precharge <= 3'h0;
      dma_ctrl <= 5'h00;
      dma_block <= `BAWC_RST_DMABLK;
    end else if (clk_en) begin
      // answer lands one edge after the request is seen
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rd_mux : 32'h00000000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (wr_go) begin
        case (avs_address)
          `BAWC_IDX_WAIT45:
            area45_wait_ctrl <= avs_writedata[7:0] & `BAWC_WAIT45_MASK;
          `BAWC_IDX_ASTATE: access_state_ctrl <= avs_writedata[7:0];
          `BAWC_IDX_CSEXT: select_extend_ctrl <= avs_writedata[15:0];
          `BAWC_IDX_DRAM: column_cycle_extend <= avs_writedata[0];
          `BAWC_IDX_REFR: post_self_refresh_precharge <= avs_writedata[2:0];
          `BAWC_IDX_DMACTL: dma_ctrl <= avs_writedata[4:0];
          `BAWC_IDX_DMABLK: dma_block <= avs_writedata[15:0];
          // status, unmapped indices and the dma count, which the sequencer loads, land here and change nothing here
          default: dma_block <= dma_block;
        endcase
      end
    end
  end

endmodule

// [verilog/bawc_defs.vh]
`ifndef BAWC_DEFS_VH
`define BAWC_DEFS_VH

// register word indices (byte address = 4 * index)
`define BAWC_IDX_WAIT45 4'h0
`define BAWC_IDX_ASTATE 4'h1
`define BAWC_IDX_CSEXT 4'h2
`define BAWC_IDX_DRAM 4'h3
`define BAWC_IDX_REFR 4'h4
`define BAWC_IDX_DMACTL 4'h5
`define BAWC_IDX_DMACNT 4'h6
`define BAWC_IDX_DMABLK 4'h7
`define BAWC_IDX_STATUS 4'h8

// reset values and the wait register write mask
`define BAWC_RST_WAIT45 8'h77
`define BAWC_RST_ASTATE 8'hff
`define BAWC_RST_CSEXT 16'h0000
`define BAWC_WAIT45_MASK 8'h77
`define BAWC_RST_DMABLK 16'h0001

// program wait fields inside area45_wait_ctrl
`define BAWC_W5_HI 6
`define BAWC_W5_LO 4
`define BAWC_W4_HI 2
`define BAWC_W4_LO 0

// dma control fields
`define BAWC_DC_EN 0
`define BAWC_DC_AUTO 1
`define BAWC_DC_EDGE 2
`define BAWC_DC_MODE_LO 3
`define BAWC_DC_MODE_HI 4
`define BAWC_MODE_STEAL 2'h0
`define BAWC_MODE_BLOCK 2'h1
`define BAWC_MODE_BURST 2'h2

// area numbers with program wait fields
`define BAWC_AREA4 3'h4
`define BAWC_AREA5 3'h5

// column cycle lengths in states
`define BAWC_COL_NORM 2'h2
`define BAWC_COL_LONG 2'h3

// grant one-hot positions, lowest priority first
`define BAWC_G_CORE 0
`define BAWC_G_ETU 1
`define BAWC_G_DMA 2
`define BAWC_G_EXDMA 3
`define BAWC_G_EXTREL 4
`define BAWC_GW 5
`define BAWC_GRANT_CORE 5'h01
`define BAWC_GRANT_ETU 5'h02
`define BAWC_GRANT_DMA 5'h04
`define BAWC_GRANT_EXDMA 5'h08
`define BAWC_GRANT_EXTREL 5'h10

`endif
